// ==== include/crsb_params.svh ====
`ifndef CRSB_PARAMS_SVH
`define CRSB_PARAMS_SVH

// Sub-addresses within the swap/misc parameter type
`define CRSB_SUB_SAVE_LOW 8'h04
`define CRSB_SUB_SAVE_HIGH 8'h05
`define CRSB_SUB_RESTORE_LOW 8'h08
`define CRSB_SUB_RESTORE_HIGH 8'h09
`define CRSB_SUB_SAVE_TRIG 8'h0b
`define CRSB_SUB_P1_BASE_LOW 8'h10
`define CRSB_SUB_P1_FLIP_HIGH 8'h11
`define CRSB_SUB_P1_CONTROL 8'h12
`define CRSB_SUB_P2_BASE_LOW 8'h18
`define CRSB_SUB_P2_FLIP_HIGH 8'h19
`define CRSB_SUB_P2_CONTROL 8'h1a
`define CRSB_SUB_DUO_BASE_LOW 8'h30
`define CRSB_SUB_DUO_FLIP_HIGH 8'h31
`define CRSB_SUB_DUO_CONTROL 8'h32
`define CRSB_SUB_BR_TYPE 8'h68
`define CRSB_SUB_BR_START_LOW 8'h69
`define CRSB_SUB_BR_LOC_HIGH 8'h6a
`define CRSB_SUB_BR_SIZE 8'h6b

// Field positions
`define CRSB_SAVE_TRIG_BIT 0
`define CRSB_SAVE_WEN_BIT 8
`define CRSB_REDIRECT_BIT 8
`define CRSB_SWAP_EN_BIT 3
`define CRSB_SKIP_BLANK_BIT 2
`define CRSB_BR_TYPE_BIT 0

// Reset values and branch size shift
`define CRSB_SKIP_BLANK_RST 1'b0
`define CRSB_BR_TYPE_RST 1'b0
`define CRSB_BR_SIZE_SHIFT 4

`endif

// ==== include/crsb_pkg.sv ====
package crsb_pkg;
  typedef enum logic [1:0] {
    CRSB_LOC_LOCAL,
    CRSB_LOC_DYNAMIC,
    CRSB_LOC_SYSTEM,
    CRSB_LOC_RESERVED
  } crsb_loc_type;

  typedef enum logic {
    CRSB_BR_NORMAL,
    CRSB_BR_RESTORE
  } crsb_br_type;
endpackage

// ==== design/crsb_top.sv ====
`timescale 1ns/1ps
`include "crsb_params.svh"

// What this block does
// - Save trigger stores 3D write-back, keeps running
// - Redirect flag overrides save enable, targets restore
// - Pipe one base from entry bits
// - Location code: local, dynamic, system, reserved
// - Pipe one flip count from bits 23:8
// - Pipe one swaps only while enable set
// - Skip-blank bit set means no blank wait
// - Second pipe swap set at 18h-1Ah
// - Duo-view swap set at 30h-32h
// - Branch settings honoured only in AGP style
// - Normal branch inserted directly into queue
// - Restore branch waits for prior commands
// - Branch start bits 23:1, bit 0 ignored
// - Branch start bits 31:24 from entry
// - Branch location decoded from bits 23:22
// - Branch size counts 16-byte units
// - Only branch header starts a branch
// - Save start used when enable set, no redirect
module crsb_top #(
  parameter int PIPES = 3
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic para_wr,
  input wire logic [7:0] para_sub,
  input wire logic [23:0] para_data,
  input wire logic agp_format,
  input wire logic branch_header,
  input wire logic prior_cmds_done,
  input wire logic save_done,
  output logic save_busy,
  output logic save_target_valid,
  output logic [31:0] save_target_addr,
  output logic [PIPES*32-1:0] swap_base_addr,
  output logic [PIPES*2-1:0] swap_location,
  output logic [PIPES*16-1:0] swap_flip_count,
  output logic [PIPES-1:0] swap_enable,
  output logic [PIPES-1:0] swap_wait_blank,
  output logic branch_req,
  output logic branch_waiting,
  output logic [31:0] branch_start_addr,
  output crsb_pkg::crsb_loc_type branch_location,
  output logic [27:0] branch_size_bytes,
  output logic branch_type_restore
);

  ////////////////////////////////////////////////////////////////////////////
  // Save and restore buffer settings

  logic [19:0] save_low_r;
  logic [7:0] save_high_r;
  logic save_wen_r;
  logic [19:0] rest_low_r;
  logic [7:0] rest_high_r;
  logic redirect_r;
  logic save_busy_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      save_low_r <= 20'h00000;
      save_high_r <= 8'h00;
      save_wen_r <= 1'b0;
      rest_low_r <= 20'h00000;
      rest_high_r <= 8'h00;
      redirect_r <= 1'b0;
    end else if (para_wr) begin
      case (para_sub)
        `CRSB_SUB_SAVE_LOW: begin
          save_low_r <= para_data[23:4];
        end
        `CRSB_SUB_SAVE_HIGH: begin
          save_high_r <= para_data[7:0];
          save_wen_r <= para_data[`CRSB_SAVE_WEN_BIT];
        end
        `CRSB_SUB_RESTORE_LOW: begin
          rest_low_r <= para_data[23:4];
        end
        `CRSB_SUB_RESTORE_HIGH: begin
          rest_high_r <= para_data[7:0];
          redirect_r <= para_data[`CRSB_REDIRECT_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Save runs alongside the stream; a new trigger wins over done
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      save_busy_r <= 1'b0;
    end else if (para_wr && para_sub == `CRSB_SUB_SAVE_TRIG && para_data[`CRSB_SAVE_TRIG_BIT]) begin
      save_busy_r <= 1'b1;
    end else if (save_done) begin
      save_busy_r <= 1'b0;
    end
  end

  assign save_busy = save_busy_r;
  assign save_target_valid = redirect_r | save_wen_r;
  assign save_target_addr = redirect_r ? {rest_high_r, rest_low_r, 4'h0}
                                       : {save_high_r, save_low_r, 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Automatic swap settings, one set per pipe

  logic [7:0] sub_base [PIPES];
  assign sub_base[0] = `CRSB_SUB_P1_BASE_LOW;
  if (PIPES > 1) begin : g_p2
    assign sub_base[1] = `CRSB_SUB_P2_BASE_LOW;
  end
  if (PIPES > 2) begin : g_duo
    assign sub_base[2] = `CRSB_SUB_DUO_BASE_LOW;
  end

  for (genvar p = 0; p < PIPES; p++) begin : g_pipe
    logic [20:0] low_r;
    logic [1:0] loc_r;
    logic [7:0] high_r;
    logic [15:0] flip_r;
    logic en_r;
    logic skip_r;
    logic [7:0] rel;

    assign rel = para_sub - sub_base[p];

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        low_r <= 21'h000000;
        loc_r <= 2'h0;
        high_r <= 8'h00;
        flip_r <= 16'h0000;
        en_r <= 1'b0;
        skip_r <= `CRSB_SKIP_BLANK_RST;
      end else if (para_wr) begin
        case (rel)
          8'h00: begin
            low_r <= para_data[23:3];
            loc_r <= para_data[1:0];
          end
          8'h01: begin
            flip_r <= para_data[23:8];
            high_r <= para_data[7:0];
          end
          8'h02: begin
            en_r <= para_data[`CRSB_SWAP_EN_BIT];
            skip_r <= para_data[`CRSB_SKIP_BLANK_BIT];
          end
          default: begin
          end
        endcase
      end
    end

    assign swap_base_addr[p*32 +: 32] = {high_r, low_r, 3'h0};
    assign swap_location[p*2 +: 2] = loc_r;
    assign swap_flip_count[p*16 +: 16] = flip_r;
    assign swap_enable[p] = en_r;
    assign swap_wait_blank[p] = en_r & ~skip_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // First branch settings

  logic br_type_r;
  logic [22:0] br_low_r;
  logic [7:0] br_high_r;
  logic [1:0] br_loc_r;
  logic [23:0] br_size_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      br_type_r <= `CRSB_BR_TYPE_RST;
      br_low_r <= 23'h000000;
      br_high_r <= 8'h00;
      br_loc_r <= 2'h0;
      br_size_r <= 24'h000000;
    end else if (para_wr && agp_format) begin
      case (para_sub)
        `CRSB_SUB_BR_TYPE: begin
          br_type_r <= para_data[`CRSB_BR_TYPE_BIT];
        end
        `CRSB_SUB_BR_START_LOW: begin
          br_low_r <= para_data[23:1];
        end
        `CRSB_SUB_BR_LOC_HIGH: begin
          br_loc_r <= para_data[23:22];
          br_high_r <= para_data[7:0];
        end
        `CRSB_SUB_BR_SIZE: begin
          br_size_r <= para_data;
        end
        default: begin
        end
      endcase
    end
  end

  assign branch_start_addr = {br_high_r, br_low_r, 1'b0};
  assign branch_location = crsb_pkg::crsb_loc_type'(br_loc_r);
  assign branch_size_bytes = {br_size_r, 4'h0};
  assign branch_type_restore = br_type_r;

  ////////////////////////////////////////////////////////////////////////////
  // Branch issue

  typedef enum logic {
    CRSB_BS_IDLE,
    CRSB_BS_WAIT
  } crsb_bstate_type;

  crsb_bstate_type bstate_r;
  logic branch_req_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bstate_r <= CRSB_BS_IDLE;
      branch_req_r <= 1'b0;
    end else begin
      branch_req_r <= 1'b0;
      case (bstate_r)
        CRSB_BS_IDLE: begin
          if (branch_header && agp_format) begin
            if (br_type_r == crsb_pkg::CRSB_BR_RESTORE && !prior_cmds_done) begin
              bstate_r <= CRSB_BS_WAIT;
            end else begin
              branch_req_r <= 1'b1;
            end
          end
        end
        CRSB_BS_WAIT: begin
          if (prior_cmds_done) begin
            branch_req_r <= 1'b1;
            bstate_r <= CRSB_BS_IDLE;
          end
        end
        default: begin
          bstate_r <= CRSB_BS_IDLE;
        end
      endcase
    end
  end

  assign branch_req = branch_req_r;
  assign branch_waiting = (bstate_r == CRSB_BS_WAIT);

endmodule

// ==== test/crsb_host.sv ====
`timescale 1ns/1ps
module crsb_host (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic save_busy,
  input wire logic branch_waiting,
  output logic save_done,
  output logic prior_cmds_done
);
  logic [2:0] cnt_r;
  logic hit;
  always_ff @(posedge ref_clk) begin
    if (reset || !(save_busy || branch_waiting)) cnt_r <= 3'h0;
    else cnt_r <= cnt_r + 3'h1;
  end
  assign hit = cnt_r == (slow ? 3'h5 : 3'h1);
  assign save_done = save_busy && hit;
  assign prior_cmds_done = branch_waiting && hit;
endmodule

// ==== test/crsb_props.sv ====
`timescale 1ns/1ps
module crsb_props #(parameter int PIPES = 3) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic para_wr,
  input wire logic [7:0] para_sub,
  input wire logic [23:0] para_data,
  input wire logic agp_format,
  input wire logic branch_header,
  input wire logic prior_cmds_done,
  input wire logic save_busy,
  input wire logic [PIPES-1:0] swap_enable,
  input wire logic branch_req,
  input wire logic branch_waiting,
  input wire logic [31:0] branch_start_addr,
  input wire logic branch_type_restore
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic hd;
  assign hd = branch_header && agp_format && !branch_waiting;
  a_save_trig_busy: assert property (para_wr && para_sub == 8'h0b && para_data[0] |=> save_busy)
    else $error("save not busy");
  a_pipe_one_en: assert property (para_wr && para_sub == 8'h12 |=> swap_enable[0] == $past(para_data[3]))
    else $error("pipe one enable");
  a_pipe_two_en: assert property (para_wr && para_sub == 8'h1a |=> swap_enable[1] == $past(para_data[3]))
    else $error("pipe two enable");
  a_duo_en: assert property (para_wr && para_sub == 8'h32 |=> swap_enable[2] == $past(para_data[3]))
    else $error("duo enable");
  a_branch_normal: assert property (hd && !branch_type_restore |=> branch_req)
    else $error("normal branch late");
  a_branch_hold: assert property (hd && branch_type_restore && !prior_cmds_done |=> branch_waiting && !branch_req)
    else $error("restore branch early");
  a_no_header_req: assert property (!(branch_header && agp_format) && !branch_waiting |=> !branch_req)
    else $error("branch without header");
  a_branch_gate: assert property (para_wr && !agp_format |=> $stable(branch_start_addr))
    else $error("branch entry not gated");
  a_branch_start: assert property (para_wr && agp_format && para_sub == 8'h69
    |=> branch_start_addr[23:0] == {$past(para_data[23:1]), 1'b0})
    else $error("branch start low");
  c_req: cover property (branch_req);
  c_save: cover property (save_busy ##1 !save_busy);
  c_wait: cover property (branch_waiting ##1 branch_req);
endmodule
bind crsb_top crsb_props #(.PIPES(PIPES)) u_props (.*);

// ==== test/crsb_top_test.sv ====
`timescale 1ns/1ps
module crsb_top_test;
  logic ref_clk = 0, reset = 1, para_wr = 0, agp_format = 0, branch_header = 0, slow = 0;
  logic [7:0] para_sub = 8'h00, sb;
  logic [23:0] para_data = 24'h0, lo, hi, ct;
  logic save_done, prior_cmds_done, save_busy, save_target_valid, branch_req, branch_waiting, branch_type_restore;
  logic [31:0] save_target_addr, branch_start_addr;
  logic [95:0] swap_base_addr;
  logic [5:0] swap_location;
  logic [47:0] swap_flip_count;
  logic [2:0] swap_enable, swap_wait_blank;
  crsb_pkg::crsb_loc_type branch_location;
  logic [27:0] branch_size_bytes;
  integer seed = 32'hdd83, error_cnt = 0, checks = 0, p, i;
  initial forever #10 ref_clk = ~ref_clk;
  crsb_top uut (.*);
  crsb_host host (.*);
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] base(input logic [23:0] l, h);
    return {h[7:0], l[23:3], 3'h0};
  endfunction
  task automatic chk(input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] s, input logic [23:0] d);
    @(posedge ref_clk);
    para_wr <= 1'b1;
    para_sub <= s;
    para_data <= d;
  endtask
  task automatic fin;
    @(posedge ref_clk);
    para_wr <= 1'b0;
    branch_header <= 1'b0;
    #1;
  endtask
  task automatic hdr;
    @(posedge ref_clk) branch_header <= 1'b1;
    fin;
  endtask
  task automatic wt(ref logic s, input logic v);
    for (int k = 0; k < 50 && s !== v; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (s !== v) begin
      error_cnt++;
      print_verdict;
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    fin;
    chk(0, {swap_enable, swap_wait_blank, save_busy, branch_type_restore});
    chk(0, {save_target_valid, branch_waiting, branch_req, save_target_addr});
    for (i = 0; i < 4; i++) begin
      for (p = 0; p < 3; p++) begin
        lo = 24'($random(seed));
        hi = 24'($random(seed));
        ct = 24'($random(seed));
        lo[1:0] = i[1:0];
        sb = p == 0 ? 8'h10 : p == 1 ? 8'h18 : 8'h30;
        wr(sb, lo);
        wr(sb + 8'h1, hi);
        wr(sb + 8'h2, ct);
        wr(sb + 8'h3, ~ct);
        fin;
        chk(base(lo, hi), swap_base_addr[p*32 +: 32]);
        chk(lo[1:0], swap_location[p*2 +: 2]);
        chk(hi[23:8], swap_flip_count[p*16 +: 16]);
        chk({ct[3], ct[3] & ~ct[2]}, {swap_enable[p], swap_wait_blank[p]});
      end
    end
    @(posedge ref_clk) agp_format <= 1'b1;
    wr(8'h68, 24'h0);
    wr(8'h69, lo);
    wr(8'h6a, hi);
    wr(8'h6b, ct);
    fin;
    chk({hi[7:0], lo[23:1], 1'b0}, branch_start_addr);
    chk(hi[23:22], branch_location);
    chk({ct, 4'h0}, branch_size_bytes);
    chk(0, {branch_req, branch_type_restore});
    hdr;
    chk(1, branch_req);
    @(posedge ref_clk) agp_format <= 1'b0;
    wr(8'h69, ~lo);
    wr(8'h68, 24'h1);
    hdr;
    chk({hi[7:0], lo[23:1], 1'b0}, branch_start_addr);
    chk(0, {branch_req, branch_type_restore});
    @(posedge ref_clk) begin
      agp_format <= 1'b1;
      slow <= 1'b1;
    end
    wr(8'h68, 24'hffffff);
    hdr;
    chk(2'b10, {branch_waiting, branch_req});
    wt(branch_req, 1'b1);
    chk(0, branch_waiting);
    wr(8'h05, 24'h15a);
    wr(8'h04, lo);
    wr(8'h09, 24'h0);
    fin;
    chk({8'h5a, lo[23:4], 4'h0}, save_target_addr);
    chk(1, save_target_valid);
    wr(8'h08, hi);
    wr(8'h09, 24'h1a5);
    wr(8'h0b, 24'h1);
    wr(8'h10, lo);
    wr(8'h10, hi);
    fin;
    chk({8'ha5, hi[23:4], 4'h0}, save_target_addr);
    chk({hi[23:3], 3'h0}, swap_base_addr[23:0]);
    chk(1, save_busy);
    wt(save_busy, 1'b0);
    print_verdict;
  end
endmodule
